/* File: temp_acq_if.sv */
`timescale 1ns/1ns
interface temp_acq_if;
  logic              start;
  logic              busy;
  logic              done;
  logic [3:0]        code;

  modport ctrl (output start, input busy, input done, input code);
  modport seq  (input start, output busy, output done, output code);
endinterface

/* File: temp_acq_seq.sv */
`timescale 1ns/1ns
`include "temp_power_rate_consts.svh"

// paces one acquisition: raises sensor_start, waits for sensor_ready,
// bounded by a timeout so a dead sensor cannot hang the request bit
module temp_acq_seq
  import temp_power_rate_pkg::*;
#(
  parameter int ACQ_CYCLES = `ACQ_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // sensor side
  output logic             sensor_start,
  input  wire logic        sensor_ready,
  input  wire logic [3:0]  sensor_code,
  // controller side
  temp_acq_if.seq          acq
);

  acq_state_e  state;
  acq_state_e  next_state;
  logic [15:0] timer;
  logic        finish;

  assign finish = (state == ACQ_WAIT) &&
                  (sensor_ready || timer == 16'(ACQ_CYCLES - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      ACQ_IDLE:  if (acq.start) next_state = ACQ_START;
      ACQ_START: next_state = ACQ_WAIT;
      ACQ_WAIT:  if (finish) next_state = ACQ_IDLE;
      default:   next_state = ACQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ACQ_IDLE;
      timer        <= 16'h0000;
      sensor_start <= 1'b0;
      acq.done     <= 1'b0;
      acq.code     <= 4'h0;
    end else begin
      state        <= next_state;
      timer        <= (state == ACQ_WAIT) ? timer + 16'h0001 : 16'h0000;
      sensor_start <= (next_state == ACQ_START);
      acq.done     <= finish;
      if (finish)
        acq.code <= sensor_code;
    end
  end

  assign acq.busy = (state != ACQ_IDLE);

endmodule

/* File: temp_power_rate_consts.svh */
`ifndef TEMP_POWER_RATE_CONSTS_SVH
`define TEMP_POWER_RATE_CONSTS_SVH

// register offsets on the control bus
`define OFS_DIE_TEMP       8'h31
`define OFS_LOW_POWER      8'h35
`define OFS_SAMPLE_RATE    8'h36

// field positions
`define TEMP_REQ_BIT       5
`define TEMP_VALID_BIT     4
`define POR_DOWN_BIT       7

// reset values
`define RST_DIE_TEMP       8'h00
`define RST_LOW_POWER      8'h00
`define RST_SAMPLE_RATE    8'h32

// acquisition timeout of the sequencer, in clock cycles
`define ACQ_TIME_NS        2000
`define CLK_PERIOD_NS      10
`define ACQ_CYCLES         (`ACQ_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: temp_power_rate_pkg.sv */
package temp_power_rate_pkg;

  typedef enum logic [1:0] {
    RATE_8K  = 2'b00,
    RATE_16K = 2'b01,
    RATE_48K = 2'b10,
    RATE_96K = 2'b11
  } sample_rate_e;

  typedef enum logic [1:0] {
    ACQ_IDLE  = 2'b00,
    ACQ_START = 2'b01,
    ACQ_WAIT  = 2'b10
  } acq_state_e;

  typedef logic [3:0] range_code_t;

endpackage

/* File: temp_power_rate_regs.sv */
`timescale 1ns/1ns
`include "temp_power_rate_consts.svh"

// Functional notes
// - writing 1 to temp_measure_request starts a die temperature acquisition
// - hardware clears temp_measure_request when the acquisition finishes
// - temp_reading_valid reads 0 while an acquisition is in progress
// - temp_reading_valid reads 1 only for a completed stored result; a sequencer timeout also sets it, storing the sensor_code of that cycle
// - low nibble reports the latest 4-bit range code; 0 means below 30 C
// - code 15 means above 140 C; codes 1..14 are rising bands
// - low_power_config bit 7: 0 powers monitor up, 1 powers it down
// - low_power_config resets to 0, monitor powered up
// - rate field: 0=8k, 1=16k, 2=48k, 3=96k sample rate
// - input_sample_rate resets to 32h, selecting 48 kHz
module temp_power_rate_regs
  import temp_power_rate_pkg::*;
#(
  parameter int ACQ_CYCLES = `ACQ_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // register port from the control bus decoder
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // temperature sensor front end
  output logic             sensor_start,
  input  wire logic        sensor_ready,
  input  wire logic [3:0]  sensor_code,
  // controls to the rest of the device
  output logic             vbat_por_enable,
  output sample_rate_e     serial_audio_input_rate
);

  temp_acq_if acq ();

  logic [1:0]       temp_spare;
  logic             temp_measure_request;
  logic             temp_reading_valid;
  range_code_t      temp_range_code;
  logic [7:0]       low_power_config;
  logic [7:0]       input_sample_rate;
  logic             start_pulse;

  // one address compare shared by every register select
  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  wire hit_temp  = addr_is(reg_addr, `OFS_DIE_TEMP);
  wire hit_lowp  = addr_is(reg_addr, `OFS_LOW_POWER);
  wire hit_rate  = addr_is(reg_addr, `OFS_SAMPLE_RATE);
  wire wr_temp   = reg_wr && hit_temp;
  wire req_write = wr_temp && reg_wdata[`TEMP_REQ_BIT];
  // request taken only when idle; a repeat during a run is dropped
  wire req_take  = req_write && !temp_measure_request;

  wire [7:0] temp_word = {temp_spare, temp_measure_request,
                          temp_reading_valid, temp_range_code};
  wire [7:0] next_rdata = hit_temp ? temp_word :
                          hit_lowp ? low_power_config :
                          hit_rate ? input_sample_rate : 8'h00;

  temp_acq_seq #(
    .ACQ_CYCLES (ACQ_CYCLES)
  ) u_seq (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .sensor_start (sensor_start),
    .sensor_ready (sensor_ready),
    .sensor_code  (sensor_code),
    .acq          (acq.seq)
  );

  assign acq.start = start_pulse;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= req_take;
    end
  end

  // request bit: software sets it, completion clears it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_measure_request <= 1'(`RST_DIE_TEMP >> `TEMP_REQ_BIT);
    end else if (req_take) begin
      temp_measure_request <= 1'b1;
    end else if (acq.done) begin
      temp_measure_request <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_reading_valid <= 1'b0;
      temp_range_code    <= 4'h0;
    end else if (req_take) begin
      temp_reading_valid <= 1'b0;
    end else if (acq.done) begin
      temp_reading_valid <= 1'b1;
      temp_range_code    <= acq.code;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_spare        <= 2'h0;
      low_power_config  <= `RST_LOW_POWER;
      input_sample_rate <= `RST_SAMPLE_RATE;
    end else begin
      if (wr_temp)
        temp_spare <= reg_wdata[7:6];
      if (reg_wr && hit_lowp)
        low_power_config <= reg_wdata;
      if (reg_wr && hit_rate)
        input_sample_rate <= reg_wdata;
    end
  end

  // outputs registered; controls follow one cycle after the register write, reg_rdata loads on a read
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata               <= 8'h00;
      vbat_por_enable         <= 1'b1;
      serial_audio_input_rate <= RATE_48K;
    end else begin
      if (reg_rd)
        reg_rdata <= next_rdata;
      vbat_por_enable <= !low_power_config[`POR_DOWN_BIT];
      serial_audio_input_rate <=
        sample_rate_e'(input_sample_rate[1:0]);
    end
  end

  a_req_clears_valid: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_take |=> !temp_reading_valid && temp_measure_request)
    else $error("valid not dropped on request");

  sequence s_done;
    temp_measure_request && acq.done;
  endsequence

  a_done_clears_req: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    s_done ##0 !req_write |=> !temp_measure_request && temp_reading_valid)
    else $error("request not cleared on done");

  a_busy_never_valid: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    acq.busy |-> !temp_reading_valid)
    else $error("valid while busy");

  a_repeat_ignored: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    temp_measure_request && req_write |=> !start_pulse)
    else $error("repeat request restarted");

  a_start_sensor: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    req_take |-> ##2 sensor_start)
    else $error("sensor not started");

  a_code_latched: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    acq.done && !req_take |=> temp_range_code == $past(acq.code))
    else $error("code not stored");

  a_por_follows: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 vbat_por_enable == !$past(low_power_config[7]))
    else $error("monitor power mismatch");

  a_rate_follows: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ##1 serial_audio_input_rate == $past(input_sample_rate[1:0]))
    else $error("rate mismatch");

  // launch chain: request taken, strobe to the sequencer, then the sensor
  sequence s_take;
    req_take;
  endsequence

  sequence s_launch;
    start_pulse ##1 sensor_start;
  endsequence

  sequence s_repeat;
    acq.busy && req_write;
  endsequence

  a_launch_chain: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    s_take
    |=> s_launch)
    else $error("launch chain broken");

  a_no_lone_start: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    sensor_start
    |-> $past(start_pulse))
    else $error("sensor started without request");

  a_req_held: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    temp_measure_request && !acq.done
    |=> temp_measure_request)
    else $error("request dropped early");

  a_req_clear_done: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    acq.done
    |=> !temp_measure_request)
    else $error("request kept after done");

  // the flag software polls must never claim a result while one is pending
  a_valid_low_req: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    temp_measure_request
    |-> !temp_reading_valid)
    else $error("valid during request");

  a_busy_has_req: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    acq.busy
    |-> temp_measure_request)
    else $error("busy without request");

  a_valid_rise: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(temp_reading_valid)
    |-> $past(acq.done))
    else $error("valid rose without result");

  a_code_stable: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !acq.done
    |=> $stable(temp_range_code))
    else $error("code moved without result");

  a_zero_code: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    acq.done && acq.code == 4'h0
    |=> temp_range_code == 4'h0)
    else $error("lowest band not stored");

  a_top_code: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    acq.done && acq.code == 4'hF
    |=> temp_range_code == 4'hF)
    else $error("highest band not stored");

  // read data is registered and must hold between reads
  a_rdata_hold: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !reg_rd
    |=> $stable(reg_rdata))
    else $error("read data moved between reads");

  a_rdata_temp: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_rd && hit_temp
    |=> reg_rdata == $past(temp_word))
    else $error("status read mismatch");

  a_lowp_write: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_wr && hit_lowp
    |=> low_power_config == $past(reg_wdata))
    else $error("power write lost");

  a_rate_write: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_wr && hit_rate
    |=> input_sample_rate == $past(reg_wdata))
    else $error("rate write lost");

  // a repeat must neither restart the sensor nor drop the pending flag
  a_start_idle_only: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    start_pulse
    |-> !acq.busy)
    else $error("start while busy");

  a_repeat_keeps_req: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    s_repeat
    |=> temp_measure_request)
    else $error("repeat disturbed request");

endmodule

/* File: temp_power_rate_regs_tb_top.sv */
`timescale 1ns/1ns
`include "temp_power_rate_consts.svh"
module temp_power_rate_regs_tb_top;
  import temp_power_rate_pkg::*;
  logic         sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, dly = 8'h04, rd_val;
  logic [3:0]   res = 4'h0, sensor_code;
  logic [7:0]   reg_rdata;
  logic         sensor_start, sensor_ready, vbat_por_enable;
  sample_rate_e rate;
  int           n_mismatch = 0, checks_done = 0, cycles = 0, n_start = 0;

  // timeout well past the slowest answering sensor (delay 0Ah)
  temp_power_rate_regs #(.ACQ_CYCLES(40)) i_temp_power_rate_regs (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sensor_start(sensor_start),
    .sensor_ready(sensor_ready), .sensor_code(sensor_code),
    .vbat_por_enable(vbat_por_enable), .serial_audio_input_rate(rate));
  temp_sensor_model i_temp_sensor_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sensor_start(sensor_start),
    .sensor_ready(sensor_ready), .sensor_code(sensor_code),
    .ready_delay(dly), .result(res));

  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (sensor_start === 1'b1) n_start++;
    cycles++;
    // generous: the whole sequence needs well under 2000 cycles
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // data sampled one and a half cycles after the taking edge, where it stands
  task rd(input logic [7:0] a);
    @(negedge sys_clk);
    reg_addr = a; reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask

  task t_reset;
    rd(`OFS_DIE_TEMP); chk(rd_val, 8'h00);
    rd(`OFS_LOW_POWER); chk(rd_val, 8'h00);
    chk({7'h00, vbat_por_enable}, 8'h01);
    rd(`OFS_SAMPLE_RATE); chk(rd_val, 8'h32);
    chk({6'h00, rate}, {6'h00, RATE_48K});
    rd(8'h40); chk(rd_val, 8'h00);
  endtask
  task t_acq(input logic [7:0] d, input logic [3:0] c, input logic chk_code);
    int i, s;
    dly = d; res = c; s = n_start;
    wr(`OFS_DIE_TEMP, 8'h20);
    rd(`OFS_DIE_TEMP); chk(rd_val & 8'h30, 8'h20);
    wr(`OFS_DIE_TEMP, 8'h20);
    for (i = 0; i < 100 && rd_val[5] !== 1'b0; i++) rd(`OFS_DIE_TEMP);
    chk({6'h00, rd_val[5:4]}, 8'h01);
    if (chk_code) chk(rd_val, {4'h1, c});
    chk(8'(n_start - s), 8'h01);
  endtask
  task t_power;
    wr(`OFS_LOW_POWER, 8'h80); @(negedge sys_clk);
    chk({7'h00, vbat_por_enable}, 8'h00);
    rd(`OFS_LOW_POWER); chk(rd_val, 8'h80);
    wr(`OFS_LOW_POWER, 8'h00); @(negedge sys_clk);
    chk({7'h00, vbat_por_enable}, 8'h01);
  endtask
  task t_rate;
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_SAMPLE_RATE, 8'h30 | 8'(i)); @(negedge sys_clk);
      chk({6'h00, rate}, 8'(i));
      rd(`OFS_SAMPLE_RATE); chk(rd_val, 8'h30 | 8'(i));
    end
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    t_reset();
    t_acq(8'h04, 4'hF, 1'b1);
    t_acq(8'h04, 4'h0, 1'b1);
    t_acq(8'h0A, 4'h7, 1'b1);
    // sensor never answers: the timeout must still end the request
    t_acq(8'hFF, 4'h0, 1'b0);
    t_power();
    t_rate();
    end_sim();
  end
endmodule

/* File: temp_sensor_model.sv */
`timescale 1ns/1ns

// behavioural sensor front end: answers a start ready_delay+1 cycles after it is seen.
// the code lines toggle outside the answer so stale values never look good.
module temp_sensor_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // sensor link
  input  wire logic       sensor_start,
  output logic            sensor_ready,
  output logic [3:0]      sensor_code,
  // scenario controls
  input  wire logic [7:0] ready_delay,
  input  wire logic [3:0] result
);
  logic [7:0] cnt;
  logic       run;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run          <= 1'b0;
      cnt          <= 8'h00;
      sensor_ready <= 1'b0;
      sensor_code  <= 4'h5;
    end else begin
      sensor_ready <= 1'b0;
      sensor_code  <= ~sensor_code;
      if (sensor_start) begin
        run <= 1'b1;
        cnt <= ready_delay;
      end else if (run && cnt == 8'h00) begin
        run          <= 1'b0;
        sensor_ready <= 1'b1;
        sensor_code  <= result;
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule
